//--- flash_ctl_defs.vh
// Purpose: constants for the flash clock, security and index registers
// Assumes: byte-wide register port, printed offsets used as addresses
// Notes: definitions only
`ifndef FLASH_CTL_DEFS_VH
`define FLASH_CTL_DEFS_VH

`define ADDR_W 16
`define OFS_CLOCK_DIVIDER 16'h0100
`define OFS_SECURITY_STATE 16'h0101
`define OFS_COMMAND_INDEX 16'h0102
`define OFS_FACTORY_TEST 16'h0103

`define BIT_DIVIDER_LOADED 7
`define BIT_DIVIDER_LOCK 6
`define DIV_MSB 5
`define DIV_LSB 0
`define BACKDOOR_KEY_ENABLE_FIELD_MSB 7
`define BACKDOOR_KEY_ENABLE_FIELD_LSB 6
`define SEC_MSB 1
`define SEC_LSB 0
`define INDEX_MSB 2
`define INDEX_LSB 0

`define BACKDOOR_KEY_ENABLE_FIELD_ENABLED 2'h2
`define SEC_UNSECURED 2'h2
`define SECURITY_FAULT_VALUE 8'hFF
`define DIVIDER_RESET 6'h00
`define INDEX_RESET 3'h0
`define SECURITY_RESET 8'hFF
`define TIMEBASE_KHZ 1000
`define BUS_CLOCK_KHZ 40000

`endif

//--- flash_timebase.v
// Purpose: divides the bus clock into a one-cycle 1 MHz tick
// Assumes: divider value and enable come from registers
// Notes: period is divider value plus one bus clocks
`timescale 1ns/1ps
`default_nettype none
module flash_timebase #(
  parameter DIV_W = 6
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_enable,
  input wire [DIV_W-1:0] i_divider,
  output reg o_tick
);
  reg [DIV_W-1:0] count;

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= {DIV_W{1'b0}};
      o_tick <= 1'b0;
    end else if (!i_enable) begin
      count <= {DIV_W{1'b0}};
      o_tick <= 1'b0;
    end else if (count >= i_divider) begin
      // Compare with >= so a smaller new value cannot strand the count
      count <= {DIV_W{1'b0}};
      o_tick <= 1'b1;
    end else begin
      count <= count + {{(DIV_W-1){1'b0}}, 1'b1};
      o_tick <= 1'b0;
    end
  end
endmodule // flash_timebase
`default_nettype wire

//--- flash_clock_security_index_regs.v
// Purpose: clock divider, security, command index and test registers
// Assumes: byte register port, read data the cycle after the strobe
// Notes: security byte is delivered by the reset-sequence loader
//
// Behaviour
// - Bit 7 reads one after any write
// - Bit 6 locks divider until reset
// - Divider field makes 1 MHz program tick
// - Divider writable during flash reset sequence
// - Security register read-only, writes ignored
// - Security loaded from stored byte at reset
// - Double fault during load sets all bits
// - Key enable only when field is 10
// - Security field 10 means unsecured
// - Backdoor unlock forces security field 10
// - Index field bits 2-0 read/write
// - Other index bits read zero
// - Factory test register reads zero
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_defs.vh"
module flash_clock_security_index_regs #(
  parameter DIV_W = 6,
  parameter IDX_W = 3
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire [15:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_sec_load,
  input wire [7:0] i_sec_byte,
  input wire i_sec_double_fault,
  input wire i_backdoor_unlock,
  output wire o_timebase_tick,
  output wire o_timing_enable,
  output wire [DIV_W-1:0] o_divider_value,
  output wire [IDX_W-1:0] o_command_word_index,
  output wire o_backdoor_key_enabled,
  output wire o_unsecured
);
  reg divider_loaded_flag;
  reg divider_lock_bit;
  reg [DIV_W-1:0] divider_value_field;
  reg [7:0] flash_security_state;
  reg backdoor_unsecured;
  reg [IDX_W-1:0] command_word_index_field;
  reg [7:0] next_rdata;
  wire [1:0] security_state_field;
  wire [1:0] backdoor_key_enable_field;
  wire wr_div;
  wire wr_idx;

  function sel;
    input [15:0] a;
    input [15:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  assign wr_div = i_wr && sel(i_addr, `OFS_CLOCK_DIVIDER);
  assign wr_idx = i_wr && sel(i_addr, `OFS_COMMAND_INDEX);

  // divider and lock writable anytime until bit 6 is set
  // Writes are not gated by command state, so reset-sequence setup works
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      divider_loaded_flag <= 1'b0;
      divider_lock_bit <= 1'b0;
      divider_value_field <= `DIVIDER_RESET;
    end else if (wr_div) begin
      divider_loaded_flag <= 1'b1;
      if (!divider_lock_bit) begin
        divider_value_field <= i_wdata[`DIV_MSB:`DIV_LSB];
        divider_lock_bit <= i_wdata[`BIT_DIVIDER_LOCK];
      end
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flash_security_state <= `SECURITY_RESET;
    end else if (i_sec_load) begin
      flash_security_state <= i_sec_double_fault ? `SECURITY_FAULT_VALUE
                                                 : i_sec_byte;
    end
  end

  // Backdoor unlock persists until the next reset
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      backdoor_unsecured <= 1'b0;
    end else if (i_backdoor_unlock) begin
      backdoor_unsecured <= 1'b1;
    end
  end

  assign security_state_field = backdoor_unsecured ? `SEC_UNSECURED :
    flash_security_state[`SEC_MSB:`SEC_LSB];
  assign backdoor_key_enable_field =
    flash_security_state[`BACKDOOR_KEY_ENABLE_FIELD_MSB:`BACKDOOR_KEY_ENABLE_FIELD_LSB];
  assign o_backdoor_key_enabled =
    (backdoor_key_enable_field == `BACKDOOR_KEY_ENABLE_FIELD_ENABLED);
  assign o_unsecured = (security_state_field == `SEC_UNSECURED);

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      command_word_index_field <= `INDEX_RESET;
    end else if (wr_idx) begin
      command_word_index_field <= i_wdata[IDX_W-1:0];
    end
  end

  always @* begin
    next_rdata = 8'h00;
    if (sel(i_addr, `OFS_CLOCK_DIVIDER)) begin
      next_rdata = {divider_loaded_flag, divider_lock_bit,
                    divider_value_field};
    end else if (sel(i_addr, `OFS_SECURITY_STATE)) begin
      next_rdata = {flash_security_state[7:2], security_state_field};
    end else if (sel(i_addr, `OFS_COMMAND_INDEX)) begin
      next_rdata = {{(8-IDX_W){1'b0}}, command_word_index_field};
    end else begin
      next_rdata = 8'h00;
    end
  end

  // Unmapped addresses and idle cycles return zero
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  assign o_timing_enable = divider_loaded_flag;
  assign o_divider_value = divider_value_field;
  assign o_command_word_index = command_word_index_field;

  flash_timebase #(
    .DIV_W(DIV_W)
  ) u_timebase (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_enable(divider_loaded_flag),
    .i_divider(divider_value_field),
    .o_tick(o_timebase_tick)
  );
endmodule // flash_clock_security_index_regs
`default_nettype wire

//--- fcsi_monitor.sv
// Purpose: port assertions for the register block
// Assumes: one clock, async active-low reset
// Notes: bound to the block
`timescale 1ns/1ps
`default_nettype none
module fcsi_monitor #(
  parameter DIV_W = 6,
  parameter IDX_W = 3
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_backdoor_unlock,
  input wire logic [7:0] o_rdata,
  input wire logic o_timebase_tick,
  input wire logic o_timing_enable,
  input wire logic [DIV_W-1:0] o_divider_value,
  input wire logic [IDX_W-1:0] o_command_word_index,
  input wire logic o_unsecured
);
  logic lk;
  wire w0 = i_wr && i_addr == 16'h0100;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // Lock shadow, only reset clears it
  always @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b) lk <= 1'b0;
    else if (w0) lk <= lk | i_wdata[6];
  a_loaded_on_write: assert property (w0 |=> o_timing_enable)
    else $error("loaded flag not set");
  a_divider_takes: assert property (w0 && !lk |=>
    o_divider_value == $past(i_wdata[5:0])) else $error("divider lost");
  a_lock_holds: assert property (w0 && lk |=> $stable(o_divider_value))
    else $error("locked divider changed");
  a_index_write: assert property (i_wr && i_addr == 16'h0102 |=>
    o_command_word_index == $past(i_wdata[2:0])) else $error("index lost");
  a_index_read: assert property (i_rd && i_addr == 16'h0102 |=>
    o_rdata == {5'h00, o_command_word_index}) else $error("index read");
  a_tick_held: assert property (!o_timing_enable |-> !o_timebase_tick)
    else $error("tick before load");
  a_tick_period: assert property ($rose(o_timebase_tick) &&
    o_divider_value == 6'h05 |=> !o_timebase_tick [*5] ##1 o_timebase_tick)
    else $error("tick period");
  a_unlock_forces: assert property (i_backdoor_unlock |=> o_unsecured)
    else $error("unlock not seen");
endmodule // fcsi_monitor
bind flash_clock_security_index_regs fcsi_monitor #(.DIV_W(DIV_W),
  .IDX_W(IDX_W)) fcsi_monitor_inst (.*);
`default_nettype wire

//--- flash_clock_security_index_regs_bench.sv
// Purpose: self-checking bench for the register block
// Assumes: read data the cycle after the strobe
// Notes: reads queue their expectation
`timescale 1ns/1ps
`default_nettype none
module flash_clock_security_index_regs_bench;
  logic i_sys_clk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, pend = 0;
  logic i_sec_load = 0, i_sec_double_fault = 0, i_backdoor_unlock = 0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00, i_sec_byte = 8'h00, o_rdata, b, q[$];
  logic [5:0] o_divider_value;
  logic [2:0] o_command_word_index;
  logic o_timebase_tick, o_timing_enable, o_backdoor_key_enabled, o_unsecured;
  logic [31:0] r = 32'h8A9A;
  int miscompares = 0, cmp_count = 0, n;
  always #12.5 i_sys_clk = ~i_sys_clk;
  flash_clock_security_index_regs flash_clock_security_index_regs_inst (.*);
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  // no command runs here, so every write is legal
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_sys_clk);
    i_wr <= 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    q.push_back(e);
    @(posedge i_sys_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_sys_clk);
    i_rd <= 0;
    @(posedge i_sys_clk);
  endtask
  task automatic pulse(ref logic s);
    @(posedge i_sys_clk);
    s <= 1;
    @(posedge i_sys_clk);
    s <= 0;
  endtask
  always @(posedge i_sys_clk) begin
    if (pend) chk(o_rdata, q.pop_front());
    pend <= i_rd;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_rst_b <= 1;
    rd(16'h0100, 8'h00);
    for (int k = 0; k < 4; k++) begin
      r = nx(r);
      b = {k[1:0], 4'hF, k[1:0]};
      i_sec_byte <= b;
      pulse(i_sec_load);
      rd(16'h0101, b);
      chk(o_unsecured, k == 2);
      chk(o_backdoor_key_enabled, k == 2);
    end
    wr(16'h0101, 8'h02);
    rd(16'h0101, b);
    i_sec_double_fault <= 1;
    pulse(i_sec_load);
    i_sec_double_fault <= 0;
    rd(16'h0101, 8'hFF);
    chk(o_backdoor_key_enabled, 0);
    pulse(i_backdoor_unlock);
    rd(16'h0101, 8'hFE);
    $display("security done");
    r = nx(r);
    wr(16'h0102, r[7:0]);
    rd(16'h0102, {5'h00, r[2:0]});
    wr(16'h0103, 8'hFF);
    rd(16'h0103, 8'h00);
    rd(16'h0200, 8'h00);
    $display("index done");
    wr(16'h0100, 8'h05);
    rd(16'h0100, 8'h85);
    for (n = 0; n < 50 && o_timebase_tick !== 1; n++) @(posedge i_sys_clk);
    chk(n < 50, 1);
    if (n >= 50) conclude();
    for (n = 1; n < 50; n++) begin
      @(posedge i_sys_clk);
      if (o_timebase_tick === 1) break;
    end
    chk(n, 6);
    if (n >= 50) conclude();
    wr(16'h0100, 8'h45);
    wr(16'h0100, 8'h0A);
    rd(16'h0100, 8'hC5);
    i_rst_b <= 0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_b <= 1;
    chk(o_timing_enable, 0);
    // divider picked for the 40 MHz bus clock
    wr(16'h0100, 8'h27);
    rd(16'h0100, 8'hA7);
    $display("divider done");
    conclude();
  end
endmodule // flash_clock_security_index_regs_bench
`default_nettype wire
